// ==== hdl/aopm_pkg.sv ====
`default_nettype none

package aopm_pkg;

   // Timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned POWER_DOWN_N_SETTLE_US = 100;
   localparam int unsigned SHDN_SETTLE_MS = 13;
   // Least times round up to whole cycles
   localparam int unsigned POWER_DOWN_N_SETTLE_CYC =
      (POWER_DOWN_N_SETTLE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int unsigned SHDN_SETTLE_CYC =
      (SHDN_SETTLE_MS * CLK_HZ + 999) / 1000;
   localparam int WAIT_W = 19;

   // Data path
   localparam int WORD_W = 16;
   localparam int NCH = 8;
   localparam int CH_W = 3;
   localparam int FIFO_DEPTH = 8;
   localparam int CNT_W = 6;
   localparam int BYTE_W = 8;
   localparam int SER_BITS_PER_CH = 16;
   localparam int SER_GROUP_TWO_BASE = 4;

   // Data pin positions
   localparam int DB_TOP = 15;
   localparam int DB_BIT14 = 14;
   localparam int DB_SER_GROUP_TWO = 8;
   localparam int DB_SER_GROUP_ONE = 7;

   // Synchronised pin vector positions
   localparam int PIN_CS = 0;
   localparam int PIN_RD = 1;
   localparam int PIN_SEL = 2;
   localparam int PIN_PD = 3;
   localparam int PIN_RANGE = 4;
   localparam int PIN_ST1 = 5;
   localparam int PIN_ST2 = 6;
   localparam int PIN_TOP = 7;
   localparam int PIN_B14 = 8;
   localparam int PIN_RST = 9;
   localparam int PIN_W = 10;
   // Idle pin levels: strobes and power-down high
   localparam logic [PIN_W-1:0] PIN_IDLE = 10'h00b;

   typedef enum logic [2:0] {
      AOPM_ON,
      AOPM_POWER_DOWN_N,
      AOPM_SHDN,
      AOPM_WAKE_POWER_DOWN_N,
      AOPM_WAKE_SHDN,
      AOPM_NEED_RESET
   } aopm_pwr_t;

   typedef enum logic [1:0] {
      AOPM_PAR,
      AOPM_BYTE,
      AOPM_SER
   } aopm_mode_t;

   typedef struct packed {
      logic [PIN_W-1:0] meta;
      logic [PIN_W-1:0] sync;
      logic prev_cs;
      logic prev_rd;
      logic prev_st1;
      logic prev_st2;
      aopm_pwr_t pwr;
      logic [WAIT_W-1:0] wait_cnt;
      logic grp_one;
      logic grp_two;
      logic busy;
      logic start_conv;
      logic start_rejected;
      logic frame;
      logic [CNT_W-1:0] rd_cnt;
      logic [CH_W-1:0] ld_idx;
      logic [NCH-1:0][WORD_W-1:0] bank;
      logic [WORD_W-1:0] db_out;
      logic [WORD_W-1:0] db_oe_n;
      logic first_data;
      logic first_data_oe_n;
      logic frontend_on;
      logic reference_on;
   } aopm_state_t;

   localparam aopm_state_t ST_RESET = '{
      meta: PIN_IDLE,
      sync: PIN_IDLE,
      prev_cs: 1'b1,
      prev_rd: 1'b1,
      prev_st1: 1'b0,
      prev_st2: 1'b0,
      pwr: AOPM_ON,
      wait_cnt: '0,
      grp_one: 1'b0,
      grp_two: 1'b0,
      busy: 1'b0,
      start_conv: 1'b0,
      start_rejected: 1'b0,
      frame: 1'b0,
      rd_cnt: '0,
      ld_idx: '0,
      bank: '0,
      db_out: '0,
      db_oe_n: '1,
      first_data: 1'b0,
      first_data_oe_n: 1'b1,
      frontend_on: 1'b1,
      reference_on: 1'b1
   };

endpackage

`default_nettype wire

// ==== hdl/aopm_fifo.sv ====
`default_nettype none

module aopm_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   // Pointers wrap naturally, so D must be a power of two
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } aopm_fifo_t;

   aopm_fifo_t st;
   aopm_fifo_t next_st;
   logic push;
   logic pop;

   always_comb begin
      push = in_valid && !st.full;
      pop = out_ready && !st.empty;
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_data;
         next_st.wr = AW'(st.wr + 1'b1);
      end
      if (pop) begin
         next_st.rd = AW'(st.rd + 1'b1);
      end
      next_st.cnt = (AW+1)'(st.cnt + {{AW{1'b0}}, push}
                            - {{AW{1'b0}}, pop});
      next_st.full = next_st.cnt == FULL_CNT;
      next_st.empty = next_st.cnt == '0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{mem: '0, wr: '0, rd: '0, cnt: '0,
                 full: 1'b0, empty: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   assign in_ready = !st.full;
   assign out_valid = !st.empty;
   assign out_data = st.mem[st.rd];

endmodule

`default_nettype wire

// ==== hdl/aopm_top.sv ====
// Summary of operation
// - Parallel mode: top pin drives result MSB
// - Selector high: top pin picks serial/byte
// - Parallel mode: second pin drives bit 14
// - Byte mode: bit-14 pin selects byte order
// - Parallel drives bits 13-9; serial: host low
// - Parallel mode: pin 8 drives bit 8
// - Byte mode: pin 8 always high impedance
// - Serial mode: pin 8 carries channels 5-8
// - Parallel mode: pin 7 drives bit 7
// - Byte mode: pin 7 is byte MSB
// - Serial mode: pin 7 carries channels 1-4
// - Parallel drives bits 6-0; serial: host low
// - Byte mode: two reads per channel word
// - Power-down low, range high: enter standby
// - Power-down low, range low: enter shutdown
// - Two start inputs sample two channel groups
// - Starts ignored while busy is high
// - Chip select rise floats, fall opens frame
`default_nettype none

module aopm_top
   import aopm_pkg::*;
#(
   parameter int unsigned SHDN_WAIT_CYC = aopm_pkg::SHDN_SETTLE_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Host control pins
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic interface_selector,
   input wire logic power_down_n,
   input wire logic range_sel,
   input wire logic sample_start_group_one,
   input wire logic sample_start_group_two,
   input wire logic conv_reset,
   // Shared data pins
   input wire logic [aopm_pkg::WORD_W-1:0] db_in,
   output logic [aopm_pkg::WORD_W-1:0] db_out,
   output logic [aopm_pkg::WORD_W-1:0] db_oe_n,
   // First channel indicator pin
   output logic first_data,
   output logic first_data_oe_n,
   // Conversion status
   output logic busy,
   output logic start_rejected,
   // Converter core
   output logic convert_start,
   input wire logic convert_done,
   input wire logic result_valid,
   input wire logic [aopm_pkg::WORD_W-1:0] result_data,
   output logic result_ready,
   // Power control
   output logic frontend_on,
   output logic reference_on
);
   import aopm_pkg::*;

   localparam logic [WAIT_W-1:0] POWER_DOWN_N_LOAD =
      WAIT_W'(POWER_DOWN_N_SETTLE_CYC - 1);
   localparam logic [WAIT_W-1:0] SHDN_LOAD =
      WAIT_W'(SHDN_WAIT_CYC - 1);

   aopm_state_t st;
   aopm_state_t next_st;
   logic rst_meta;
   logic rst_n;
   logic fifo_valid;
   logic fifo_pop;
   logic [WORD_W-1:0] fifo_data;

   function automatic logic rise(input logic cur, input logic prev);
      return cur && !prev;
   endfunction

   function automatic aopm_mode_t decode_mode(input logic sel,
                                              input logic top);
      if (!sel) begin
         return AOPM_PAR;
      end else if (top) begin
         return AOPM_BYTE;
      end else begin
         return AOPM_SER;
      end
   endfunction

   function automatic logic [BYTE_W-1:0] pick_byte(
      input logic [WORD_W-1:0] word,
      input logic second,
      input logic hi_first);
      if (second == hi_first) begin
         return word[BYTE_W-1:0];
      end else begin
         return word[WORD_W-1:BYTE_W];
      end
   endfunction

   function automatic logic ser_bit(
      input logic [NCH-1:0][WORD_W-1:0] bank,
      input logic [CH_W-1:0] ch,
      input logic [3:0] pos);
      logic [3:0] bit_idx;
      bit_idx = 4'hf - pos;
      return bank[ch][bit_idx];
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Results queue between converter core and output port
   aopm_fifo #(
      .W(WORD_W),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(result_valid),
      .in_ready(result_ready),
      .in_data(result_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   always_comb begin
      logic cs_fall;
      logic cs_rise;
      logic rd_rise;
      logic rd_fall;
      logic st1_rise;
      logic st2_rise;
      logic ready;
      logic reading;
      logic [CH_W-1:0] ch;
      aopm_mode_t mode;
      logic [WORD_W-1:0] word;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      rd_rise = 1'b0;
      rd_fall = 1'b0;
      st1_rise = 1'b0;
      st2_rise = 1'b0;
      ready = 1'b0;
      reading = 1'b0;
      ch = '0;
      mode = AOPM_PAR;
      word = '0;
      next_st = st;
      fifo_pop = 1'b0;

      // Pins pass two flip-flops before any logic looks at them
      next_st.meta = {conv_reset, db_in[DB_BIT14], db_in[DB_TOP],
                      sample_start_group_two, sample_start_group_one,
                      range_sel, power_down_n, interface_selector,
                      rd_n, cs_n};
      next_st.sync = st.meta;
      next_st.prev_cs = st.sync[PIN_CS];
      next_st.prev_rd = st.sync[PIN_RD];
      next_st.prev_st1 = st.sync[PIN_ST1];
      next_st.prev_st2 = st.sync[PIN_ST2];

      cs_fall = rise(st.prev_cs, st.sync[PIN_CS]);
      cs_rise = rise(st.sync[PIN_CS], st.prev_cs);
      rd_fall = rise(st.prev_rd, st.sync[PIN_RD]);
      rd_rise = rise(st.sync[PIN_RD], st.prev_rd);
      st1_rise = rise(st.sync[PIN_ST1], st.prev_st1);
      st2_rise = rise(st.sync[PIN_ST2], st.prev_st2);
      mode = decode_mode(st.sync[PIN_SEL], st.sync[PIN_TOP]);

      next_st.start_conv = 1'b0;
      next_st.start_rejected = 1'b0;

      // Power state; entry overrides whatever is in progress
      if (!st.sync[PIN_PD]) begin
         if (st.sync[PIN_RANGE]) begin
            next_st.pwr = AOPM_POWER_DOWN_N;
         end else begin
            next_st.pwr = AOPM_SHDN;
         end
         next_st.grp_one = 1'b0;
         next_st.grp_two = 1'b0;
         next_st.busy = 1'b0;
      end else begin
         case (st.pwr)
            AOPM_ON: begin
               if (st.sync[PIN_RST]) begin
                  next_st.grp_one = 1'b0;
                  next_st.grp_two = 1'b0;
                  next_st.busy = 1'b0;
               end
            end
            AOPM_POWER_DOWN_N: begin
               next_st.pwr = AOPM_WAKE_POWER_DOWN_N;
               next_st.wait_cnt = POWER_DOWN_N_LOAD;
            end
            AOPM_SHDN: begin
               next_st.pwr = AOPM_WAKE_SHDN;
               next_st.wait_cnt = SHDN_LOAD;
            end
            AOPM_WAKE_POWER_DOWN_N: begin
               if (st.wait_cnt == '0) begin
                  next_st.pwr = AOPM_ON;
               end else begin
                  next_st.wait_cnt = WAIT_W'(st.wait_cnt - 1'b1);
               end
            end
            AOPM_WAKE_SHDN: begin
               if (st.wait_cnt == '0) begin
                  next_st.pwr = AOPM_NEED_RESET;
               end else begin
                  next_st.wait_cnt = WAIT_W'(st.wait_cnt - 1'b1);
               end
            end
            AOPM_NEED_RESET: begin
               if (st.sync[PIN_RST]) begin
                  next_st.pwr = AOPM_ON;
               end
            end
            default: begin
               next_st.pwr = AOPM_SHDN;
            end
         endcase
      end

      // Sampling control
      ready = st.pwr == AOPM_ON && st.sync[PIN_PD] && !st.sync[PIN_RST];
      if (st1_rise || st2_rise) begin
         if (!ready) begin
            next_st.start_rejected = 1'b1;
         end else if (!st.busy) begin
            if (st1_rise) begin
               next_st.grp_one = 1'b1;
            end
            if (st2_rise) begin
               next_st.grp_two = 1'b1;
            end
         end
      end
      // Conversion starts once both groups are held
      if (ready && !st.busy && next_st.grp_one && next_st.grp_two) begin
         next_st.busy = 1'b1;
         next_st.start_conv = 1'b1;
         next_st.grp_one = 1'b0;
         next_st.grp_two = 1'b0;
      end else if (st.busy && convert_done && ready) begin
         next_st.busy = 1'b0;
      end

      // Results move into the read bank only between frames, so the
      // bank holds still while a frame is open; the queue absorbs a
      // conversion that lands while the host is reading.
      if (fifo_valid && !st.frame) begin
         fifo_pop = 1'b1;
         next_st.bank[st.ld_idx] = fifo_data;
         next_st.ld_idx = CH_W'(st.ld_idx + 1'b1);
      end

      // Output frame
      if (cs_fall) begin
         next_st.frame = 1'b1;
         next_st.rd_cnt = '0;
      end else if (cs_rise) begin
         next_st.frame = 1'b0;
      end else if (st.frame) begin
         if ((mode == AOPM_SER) ? rd_fall : rd_rise) begin
            next_st.rd_cnt = CNT_W'(st.rd_cnt + 1'b1);
         end
      end

      // Pin drive; every pin floats unless the mode claims it
      reading = next_st.frame && !st.sync[PIN_RD];
      next_st.db_out = '0;
      next_st.db_oe_n = '1;
      next_st.first_data = 1'b0;
      next_st.first_data_oe_n = !next_st.frame;
      case (mode)
         AOPM_PAR: begin
            ch = next_st.rd_cnt[CH_W-1:0];
            word = next_st.bank[ch];
            if (reading) begin
               next_st.db_out = word;
               next_st.db_oe_n = '0;
            end
            next_st.first_data = next_st.frame && ch == '0
                                 && next_st.rd_cnt < CNT_W'(NCH);
         end
         AOPM_BYTE: begin
            // Top and bit-14 pins stay inputs; pin 8 stays floating
            ch = next_st.rd_cnt[CH_W:1];
            word = next_st.bank[ch];
            if (reading) begin
               next_st.db_out[BYTE_W-1:0] =
                  pick_byte(word, next_st.rd_cnt[0],
                            st.sync[PIN_B14]);
               next_st.db_oe_n[BYTE_W-1:0] = '0;
            end
            next_st.first_data = next_st.frame && next_st.rd_cnt < 6'h02;
         end
         AOPM_SER: begin
            // Byte-order and unused data pins are held low by the host
            ch = CH_W'(next_st.rd_cnt[CNT_W-1:4]);
            if (next_st.frame) begin
               next_st.db_out[DB_SER_GROUP_ONE] =
                  ser_bit(next_st.bank, ch,
                          next_st.rd_cnt[3:0]);
               next_st.db_out[DB_SER_GROUP_TWO] =
                  ser_bit(next_st.bank,
                          CH_W'(ch + CH_W'(SER_GROUP_TWO_BASE)),
                          next_st.rd_cnt[3:0]);
               next_st.db_oe_n[DB_SER_GROUP_ONE] = 1'b0;
               next_st.db_oe_n[DB_SER_GROUP_TWO] = 1'b0;
            end
            next_st.first_data = next_st.frame
               && next_st.rd_cnt < CNT_W'(SER_BITS_PER_CH);
         end
         default: begin
            next_st.db_oe_n = '1;
         end
      endcase

      next_st.frontend_on = next_st.pwr == AOPM_ON;
      next_st.reference_on = next_st.pwr != AOPM_SHDN;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign db_out = st.db_out;
   assign db_oe_n = st.db_oe_n;
   assign first_data = st.first_data;
   assign first_data_oe_n = st.first_data_oe_n;
   assign busy = st.busy;
   assign start_rejected = st.start_rejected;
   assign convert_start = st.start_conv;
   assign frontend_on = st.frontend_on;
   assign reference_on = st.reference_on;

endmodule

`default_nettype wire

// ==== dv/aopm_props.sv ====
`default_nettype none

module aopm_props
   import aopm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Host pins
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic interface_selector,
   input wire logic power_down_n,
   input wire logic range_sel,
   input wire logic sample_start_group_one,
   input wire logic [aopm_pkg::WORD_W-1:0] db_in,
   // Block outputs
   input wire logic [aopm_pkg::WORD_W-1:0] db_oe_n,
   input wire logic busy,
   input wire logic start_rejected,
   input wire logic convert_start,
   input wire logic frontend_on,
   input wire logic reference_on
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] up;
   logic [3:0] age;
   logic [3:0] low;
   logic [3:0] ctl_q;
   logic [3:0] ctl;
   logic steady;
   logic strobed;
   // Pin 15 is only a mode input while the selector is high
   assign ctl = {interface_selector, interface_selector & db_in[15],
      power_down_n, range_sel};
   // Pins cross two syncs, so judge only levels that have settled
   assign steady = (ctl == ctl_q) && (age > 4'h5);
   assign strobed = !cs_n && !rd_n && (low > 4'h4);
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         up <= 4'h0;
         age <= 4'h0;
         low <= 4'h0;
         ctl_q <= 4'h0;
      end else begin
         ctl_q <= ctl;
         up <= up + 4'(up != 4'hf);
         age <= (ctl != ctl_q) ? 4'h0 : age + 4'(age != 4'hf);
         low <= (cs_n || rd_n) ? 4'h0 : low + 4'(low != 4'hf);
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (up != 4'hf);
   property p_start_busy;
      convert_start |-> $rose(busy);
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("start pulse without busy rising");
   property p_ignore;
      $past(busy) |-> !convert_start;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("start issued while busy");
   property p_cs_float;
      $rose(cs_n) |-> ##[2:5] (db_oe_n == 16'hffff);
   endproperty
   a_cs_float: assert property (p_cs_float)
      else $error("pins still driven after chip select rose");
   property p_byte_float;
      steady && interface_selector && db_in[15] |-> db_oe_n[15:8] == 8'hff;
   endproperty
   a_byte_float: assert property (p_byte_float)
      else $error("upper pins driven in byte mode");
   property p_ser_quiet;
      steady && interface_selector && !db_in[15]
         |-> (db_oe_n | 16'h0180) == 16'hffff;
   endproperty
   a_ser_quiet: assert property (p_ser_quiet)
      else $error("tied pins driven in serial mode");
   property p_par_drive;
      steady && !interface_selector && strobed |-> db_oe_n == 16'h0000;
   endproperty
   a_par_drive: assert property (p_par_drive)
      else $error("parallel read without all pins driven");
   property p_power;
      steady && !power_down_n
         |-> !frontend_on && (reference_on == range_sel);
   endproperty
   a_power: assert property (p_power)
      else $error("power outputs wrong while powered down");
   property p_reject;
      steady && !power_down_n && $rose(sample_start_group_one)
         |-> ##[2:5] start_rejected;
   endproperty
   a_reject: assert property (p_reject)
      else $error("start while powered down not flagged");
endmodule

`default_nettype wire

// ==== dv/aopm_core_model.sv ====
`default_nettype none

module aopm_core_model
   import aopm_pkg::*;
(
   // Block side
   input wire logic clk,
   input wire logic start,
   output logic done,
   output logic valid,
   input wire logic ready,
   output logic [aopm_pkg::WORD_W-1:0] data,
   // Pattern and pacing from the bench
   input wire logic [aopm_pkg::WORD_W-1:0] base,
   input wire logic [7:0] dly
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = -1;
   int idx = 0;
   initial begin
      done = 1'b0;
      valid = 1'b0;
      data = 16'h0000;
   end
   // Word i of a conversion is base ^ (16'h1111 * i)
   always @(posedge clk) begin
      done <= 1'b0;
      if (valid && ready) begin
         if (idx == NCH - 1) begin
            valid <= 1'b0;
            // Released data must not look like a held word
            data <= ~data;
            done <= 1'b1;
         end else begin
            idx <= idx + 1;
            data <= base ^ (16'h1111 * 16'(idx + 1));
         end
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (cnt == 0) begin
         cnt <= -1;
         idx <= 0;
         valid <= 1'b1;
         data <= base;
      end else if (start === 1'b1 && !valid) begin
         cnt <= int'(dly);
      end
   end
endmodule

`default_nettype wire

// ==== dv/aopm_top_tb.sv ====
`default_nettype none

module aopm_top_tb
   import aopm_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SHDN_CYC = 50;
   localparam int LIMIT = 10000;
   logic ref_clk, reset_n, cs_n, rd_n, sel, pd_n, rng, st1, st2, crst;
   logic fd, fd_oe, busy, rej, cstart, cdone, rvalid, rready, fe_on, ref_on;
   logic [WORD_W-1:0] host, db_pin, db_out, db_oe_n, rdata, base;
   logic [7:0] dly;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   int nstart = 0;
   int nrej = 0;
   // The block wins wherever it drives a shared pin
   assign db_pin = (db_out & ~db_oe_n) | (host & db_oe_n);
   aopm_top #(.SHDN_WAIT_CYC(SHDN_CYC)) uut (
      .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
      .interface_selector(sel), .power_down_n(pd_n), .range_sel(rng),
      .sample_start_group_one(st1), .sample_start_group_two(st2),
      .conv_reset(crst), .db_in(db_pin), .db_out(db_out),
      .db_oe_n(db_oe_n), .first_data(fd), .first_data_oe_n(fd_oe),
      .busy(busy), .start_rejected(rej), .convert_start(cstart),
      .convert_done(cdone), .result_valid(rvalid), .result_data(rdata),
      .result_ready(rready), .frontend_on(fe_on), .reference_on(ref_on));
   aopm_core_model core (.clk(ref_clk), .start(cstart), .done(cdone),
      .valid(rvalid), .ready(rready), .data(rdata), .base(base),
      .dly(dly));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cstart === 1'b1) nstart <= nstart + 1;
      if (rej === 1'b1) nrej <= nrej + 1;
      if (cycles == LIMIT) begin
         fails++;
         complete_run();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic check(input logic [WORD_W-1:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [WORD_W-1:0] w(input int i);
      return base ^ (16'h1111 * 16'(i));
   endfunction
   task automatic conv(input int gap);
      st1 <= 1'b1;
      wt(gap);
      st2 <= 1'b1;
      wt(6);
      st1 <= 1'b0;
      st2 <= 1'b0;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
         wt(1);
         n++;
      end
      check(16'(n < 500), 16'h1);
   endtask
   task automatic rej_pulse();
      int r0;
      r0 = nrej;
      st1 <= 1'b1;
      wt(8);
      st1 <= 1'b0;
      wt(2);
      check(16'(nrej - r0), 16'h1);
   endtask
   // Fill the FIFO with a frame open, then drain and read all channels
   task automatic t_par();
      sel <= 1'b0;
      cs_n <= 1'b0;
      conv(3);
      check(16'(busy), 16'h1);
      wt(40);
      check(16'(rready), 16'h0);
      cs_n <= 1'b1;
      wait_done();
      wt(16);
      check(16'(rready), 16'h1);
      check(16'(nstart), 16'h1);
      cs_n <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd_n <= 1'b0;
         wt(6);
         check(db_oe_n, 16'h0000);
         check(db_out, w(i));
         check(16'(fd), 16'(i == 0));
         rd_n <= 1'b1;
         wt(6);
      end
      check(16'(fd_oe), 16'h0);
      cs_n <= 1'b1;
      wt(6);
      check(db_oe_n, 16'hffff);
      check(16'(fd_oe), 16'h1);
   endtask
   task automatic t_byte();
      logic [WORD_W-1:0] wd;
      sel <= 1'b1;
      for (int h = 0; h < 2; h++) begin
         host <= {1'b1, 1'(h), 14'h0};
         wt(6);
         cs_n <= 1'b0;
         for (int k = 0; k < 4; k++) begin
            wd = w(k / 2);
            rd_n <= 1'b0;
            wt(6);
            check(db_oe_n, 16'hff00);
            check(16'(db_out[7:0]),
               16'((h + k) % 2 ? wd[15:8] : wd[7:0]));
            check(16'(fd), 16'(k < 2));
            rd_n <= 1'b1;
            wt(6);
         end
         cs_n <= 1'b1;
         wt(6);
      end
   endtask
   task automatic t_ser();
      logic [WORD_W-1:0] a, c;
      a = w(0);
      c = w(4);
      host <= 16'h0000;
      wt(6);
      cs_n <= 1'b0;
      for (int b = 0; b < 16; b++) begin
         wt(6);
         check(db_oe_n, 16'hfe7f);
         check(16'(db_out[8:7]), 16'({c[15 - b], a[15 - b]}));
         check(16'(fd), 16'h1);
         rd_n <= 1'b0;
         wt(6);
         rd_n <= 1'b1;
      end
      wt(6);
      cs_n <= 1'b1;
      wt(6);
   endtask
   // A slow core keeps busy up while fresh start edges arrive
   task automatic t_busy();
      int n0;
      n0 = nstart;
      dly <= 8'd60;
      conv(0);
      wt(10);
      conv(2);
      wait_done();
      // Room for a wrongly armed start to fire after busy drops
      wt(8);
      check(16'(nstart - n0), 16'h1);
      dly <= 8'd4;
      wt(16);
   endtask
   task automatic t_pwr();
      int n0;
      for (int m = 0; m < 2; m++) begin
         rng <= 1'(m == 0);
         pd_n <= 1'b0;
         wt(8);
         check(16'({fe_on, ref_on}), 16'(m == 0));
         rej_pulse();
         pd_n <= 1'b1;
         wt(m == 0 ? 1000 : SHDN_CYC / 2);
         rej_pulse();
         wt(m == 0 ? 1020 : SHDN_CYC);
         if (m == 1) begin
            rej_pulse();
            crst <= 1'b1;
            wt(6);
            crst <= 1'b0;
            wt(6);
         end
         n0 = nstart;
         conv(0);
         wait_done();
         check(16'(nstart - n0), 16'h1);
         check(16'({fe_on, ref_on}), 16'h3);
         wt(16);
      end
   endtask
   initial begin
      reset_n = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      sel = 1'b0;
      pd_n = 1'b1;
      rng = 1'b1;
      st1 = 1'b0;
      st2 = 1'b0;
      crst = 1'b0;
      host = 16'h0000;
      base = 16'hc35a;
      dly = 8'd4;
      wt(12);
      reset_n <= 1'b1;
      wt(8);
      t_par();
      t_byte();
      t_ser();
      t_busy();
      t_pwr();
      complete_run();
   end
endmodule

bind aopm_top aopm_props props (.ref_clk(ref_clk), .reset_n(reset_n),
   .cs_n(cs_n), .rd_n(rd_n), .interface_selector(interface_selector),
   .power_down_n(power_down_n), .range_sel(range_sel),
   .sample_start_group_one(sample_start_group_one), .db_in(db_in),
   .db_oe_n(db_oe_n), .busy(busy), .start_rejected(start_rejected),
   .convert_start(convert_start), .frontend_on(frontend_on),
   .reference_on(reference_on));

`default_nettype wire
